// *** bmcs_pkg.sv ***
`default_nettype none
package bmcs_pkg;
    // Register map, byte addresses
    localparam logic [15:0] ADDR_FW_REV    = 16'h3E80;
    localparam logic [15:0] ADDR_FW_OPT_LO = 16'h3E84;
    localparam logic [15:0] ADDR_FW_OPT_HI = 16'h3E85;
    localparam logic [15:0] ADDR_RESP_TO   = 16'h3E8E;
    localparam logic [15:0] ADDR_INT_RESET = 16'h3FE0;
    localparam logic [15:0] ADDR_BCAST     = 16'h3FE8;
    localparam logic [15:0] ADDR_MODE_SA   = 16'h3FEA;
    localparam logic [15:0] ADDR_NMP_LO    = 16'h3FF2;
    localparam logic [15:0] ADDR_NMP_HI    = 16'h3FF3;
    localparam logic [15:0] ADDR_TRIG_EBP  = 16'h3FF4;
    localparam logic [15:0] ADDR_CNT_EBP   = 16'h3FF5;
    localparam logic [15:0] ADDR_TT_RES    = 16'h3FF7;
    localparam logic [15:0] ADDR_STATUS    = 16'h3FFA;
    localparam logic [15:0] ADDR_INT_EN    = 16'h3FFB;

    // Field positions
    localparam int STAT_CTM_BIT  = 2;
    localparam int STAT_RIP_BIT  = 1;
    localparam int STAT_TWB_BIT  = 0;
    localparam int FW_1760_BIT   = 9;
    localparam int FW_1553_BIT   = 8;

    // Reset values
    localparam logic [7:0] RESP_TO_RESET = 8'h0E;
    localparam logic [7:0] REG8_RESET    = 8'h00;
    localparam logic [15:0] PTR_RESET    = 16'h0000;

    // Ranges
    localparam logic [7:0]  MSG_CNT_MAX   = 8'hC7;
    localparam logic [16:0] LL_AREA_END   = 17'h03400;
    localparam logic [16:0] LL_SPILL_END  = 17'h0347E;
    localparam logic [15:0] NMP_MAX       = 16'h33FE;
    localparam logic [4:0]  SA_ZERO       = 5'h00;
    localparam logic [4:0]  SA_31         = 5'h1F;
    localparam logic [4:0]  RT_BCAST      = 5'h1F;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TT_STEP_NS    = 4000;
    localparam int BUSY_HOLD_NS  = 5000;
    localparam int US_NS         = 1000;
    localparam logic [5:0] TT_STEP_CYC =
        6'((TT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] BUSY_CYC = 6'(BUSY_HOLD_NS / CLK_PERIOD_NS);
    localparam logic [3:0] US_CYC   = 4'((US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        BMCS_SEQ = 2'b00,
        BMCS_LL  = 2'b01,
        BMCS_LUT = 2'b10
    } bmcs_mode_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bmcs_bus_type;

    typedef struct packed {
        logic       start;
        logic       done;
        logic       trig_word;
        logic [5:0] len;
        logic [7:0] lut_block;
    } bmcs_msg_type;

    typedef struct packed {
        logic [4:0] rt_addr;
        logic [4:0] subaddr;
        logic       resp_start;
        logic       resp_seen;
    } bmcs_cmd_type;
endpackage
`default_nettype wire

// *** bmcs_regs.sv ***
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Interrupt enable bits 2,1,0 gate counter match, reception, trigger word.
// R2: Interrupt output rises only at the end of a bus message.
// R3: Software programs interrupt enables before start, changes only while halted.
// R4: Status bits 2,1,0 report match, reception, trigger/busy; bits 7..3 zero.
// R5: Status bit 0 is trigger word in sequential mode, busy otherwise.
// R6: Busy set with reception, cleared about 5 us after message end.
// R7: Match and reception flags are cleared only by software; busy is also cleared by the device.
// R8: Time tag steps every (N+1) times 4 us.
// R9: Software writes time tag resolution only while halted.
// R10: Sequential mode message counter runs 0 to 199, one step per message.
// R11: First counter increment happens when the second message starts.
// R12: Counter equal to trigger value sets match flag and enabled interrupt.
// R13: Stop-on-trigger stops monitoring at match, else monitoring continues.
// R14: End buffer pointer records spill end of final message, zero before wrap.
// R15: Next message pointer advances per stored message, cycling 0 to 33FE.
// R16: Lookup mode last block register loads block number at message end.
// R17: Two-bit field picks subaddress 0, 31 or both as mode code.
// R18: Broadcast bit makes terminal address 31 a broadcast.
// R19: Status response valid only within programmed microseconds, default 14.
// R20: Firmware options bit 9 means 1760, bit 8 means 1553.
// R21: Firmware revision holds major in upper, minor in lower nibble.
// R22: Stop-on-trigger input set and match stops message storage.
// R23: Any write to interrupt reset location deasserts the interrupt; here a message-end raise in the same cycle wins and irq stays high.
module bmcs_regs
    import bmcs_pkg::*;
#(
    parameter logic [3:0] FW_MAJOR   = 4'h1,  // Arbitrary value
    parameter logic [3:0] FW_MINOR   = 4'h0,  // Arbitrary value
    parameter logic       FW_IS_1760 = 1'b0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Register port
    input  wire bmcs_bus_type bus,
    output logic [7:0]        rdata,
    // Board control
    input  wire bmcs_mode_type op_mode,
    input  wire logic         run,
    input  wire logic         stop_on_trigger,
    output logic              store_en,
    // Monitored traffic
    input  wire bmcs_msg_type msg,
    input  wire bmcs_cmd_type cmd,
    output logic              is_mode_code,
    output logic              is_broadcast,
    output logic              resp_valid,
    output logic              resp_late,
    // Time tag and interrupt
    output logic [15:0]       time_tag,
    output logic              irq
);

    // Software registers
    logic [2:0]  int_en_reg;
    logic [7:0]  tt_res_reg;
    logic [7:0]  trig_reg;
    logic [1:0]  mode_sa_reg;
    logic        bcast_reg;
    logic [7:0]  resp_to_reg;
    logic [2:0]  stat_reg;
    logic [2:0]  stat_next;
    // Device state
    logic [7:0]  msg_cnt_reg;
    logic [7:0]  msg_cnt_next;
    logic        first_seen_reg;
    logic        stopped_reg;
    logic [15:0] nmp_reg;
    logic [15:0] ebp_reg;
    logic [7:0]  last_blk_reg;
    logic [5:0]  busy_tmr_reg;
    logic [5:0]  pre_reg;
    logic [7:0]  stp_reg;
    logic [15:0] tt_reg;
    logic [2:0]  pend_reg;
    logic        irq_reg;
    logic        resp_act_reg;
    logic [3:0]  us_pre_reg;
    logic [7:0]  us_cnt_reg;
    logic        resp_valid_reg;
    logic        resp_late_reg;
    logic [7:0]  rdata_reg;

    // Decode
    wire wr_int_en  = bus.wr && bus.addr == ADDR_INT_EN;
    wire wr_tt_res  = bus.wr && bus.addr == ADDR_TT_RES;
    wire wr_trig    = bus.wr && bus.addr == ADDR_TRIG_EBP && op_mode == BMCS_SEQ;
    wire wr_mode_sa = bus.wr && bus.addr == ADDR_MODE_SA;
    wire wr_bcast   = bus.wr && bus.addr == ADDR_BCAST;
    wire wr_resp_to = bus.wr && bus.addr == ADDR_RESP_TO;
    wire wr_status  = bus.wr && bus.addr == ADDR_STATUS;
    wire wr_int_rst = bus.wr && bus.addr == ADDR_INT_RESET;

    wire mode_seq   = op_mode == BMCS_SEQ;
    wire mode_ll    = op_mode == BMCS_LL;
    wire mode_lut   = op_mode == BMCS_LUT;
    wire active     = run && !stopped_reg;

    // Message counter
    wire cnt_inc    = mode_seq && active && msg.start && first_seen_reg;  // [R11]
    assign msg_cnt_next = (msg_cnt_reg == MSG_CNT_MAX) ? REG8_RESET
                                                       : msg_cnt_reg + 8'h01;  // [R10]
    wire match_evt  = cnt_inc && msg_cnt_next == trig_reg;  // [R12]

    // Event sources for status and interrupt
    wire ev_rip     = active && msg.start;
    wire ev_tw      = mode_seq && active && msg.trig_word;  // [R5]
    wire ev_busy    = !mode_seq && ev_rip;  // [R6]
    wire busy_end   = !mode_seq && busy_tmr_reg == 6'h01;  // [R6]
    wire [2:0] ev_set = {match_evt, ev_rip, ev_tw || ev_busy};  // [R4]
    wire [2:0] clr_bits = wr_status ? bus.wdata[2:0] : 3'h0;

    // Set wins over software clear
    assign stat_next = ev_set | (stat_reg & ~clr_bits & ~{2'b00, busy_end});  // [R7]

    // Interrupt sources, mode qualified
    wire [2:0] int_src  = int_en_reg & {match_evt, ev_rip, ev_tw};  // [R1]
    // Run, not active: a stop on trigger must still deliver the match interrupt
    wire       irq_set  = run && msg.done && |(pend_reg | int_src);  // [R2]

    // Linked-list pointer arithmetic
    wire [16:0] nmp_sum  = {1'b0, nmp_reg} + {10'h000, msg.len, 1'b0};
    wire        ll_final = nmp_sum >= LL_AREA_END;
    wire [16:0] ebp_cap  = (nmp_sum > LL_SPILL_END) ? LL_SPILL_END : nmp_sum;

    // Time tag prescaler
    wire pre_wrap = pre_reg == TT_STEP_CYC - 6'h01;
    wire tt_step  = run && pre_wrap && stp_reg == tt_res_reg;  // [R8]

    // Response window
    wire us_tick  = resp_act_reg && us_pre_reg == US_CYC - 4'h1;
    wire in_time  = us_cnt_reg < resp_to_reg;  // [R19]
    // Window closes on the tick that brings the count to the limit
    wire [8:0] us_next = {1'b0, us_cnt_reg} + 9'h001;
    wire       expire  = us_tick && us_next >= {1'b0, resp_to_reg};

    // Software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_en_reg  <= 3'h0;
            tt_res_reg  <= REG8_RESET;
            trig_reg    <= REG8_RESET;
            mode_sa_reg <= 2'h0;
            bcast_reg   <= 1'b0;
            resp_to_reg <= RESP_TO_RESET;  // [R19]
        end else begin
            if (wr_int_en)  int_en_reg  <= bus.wdata[2:0];  // [R1]
            if (wr_tt_res)  tt_res_reg  <= bus.wdata;
            if (wr_trig)    trig_reg    <= bus.wdata;
            if (wr_mode_sa) mode_sa_reg <= bus.wdata[1:0];
            if (wr_bcast)   bcast_reg   <= bus.wdata[0];
            if (wr_resp_to) resp_to_reg <= bus.wdata;
        end
    end

    // Status flags and busy hold timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg     <= 3'h0;
            busy_tmr_reg <= 6'h00;
        end else begin
            stat_reg <= stat_next;
            if (ev_busy)
                busy_tmr_reg <= 6'h00;
            else if (!mode_seq && msg.done)
                busy_tmr_reg <= BUSY_CYC;  // [R6]
            else if (busy_tmr_reg != 6'h00)
                busy_tmr_reg <= busy_tmr_reg - 6'h01;
        end
    end

    // Sequential mode counter and stop-on-trigger
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_cnt_reg    <= REG8_RESET;
            first_seen_reg <= 1'b0;
            stopped_reg    <= 1'b0;
        end else begin
            if (!run) begin
                first_seen_reg <= 1'b0;
                stopped_reg    <= 1'b0;
            end else if (mode_seq && active && msg.start) begin
                first_seen_reg <= 1'b1;  // [R11]
            end
            if (cnt_inc)
                msg_cnt_reg <= msg_cnt_next;  // [R10]
            if (match_evt && stop_on_trigger)
                stopped_reg <= 1'b1;  // [R13] [R22]
        end
    end

    assign store_en = active;  // [R22]

    // Linked-list and lookup-table pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmp_reg      <= PTR_RESET;
            ebp_reg      <= PTR_RESET;
            last_blk_reg <= REG8_RESET;
        end else if (run && msg.done) begin
            if (mode_ll && ll_final) begin
                // Final message spills, never wraps mid-message
                ebp_reg <= ebp_cap[15:0];  // [R14]
                nmp_reg <= PTR_RESET;  // [R15]
            end else if (mode_ll) begin
                nmp_reg <= nmp_sum[15:0];  // [R15]
            end
            if (mode_lut)
                last_blk_reg <= msg.lut_block;  // [R16]
        end
    end

    // Time tag counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 6'h00;
            stp_reg <= REG8_RESET;
            tt_reg  <= 16'h0000;
        end else if (run) begin
            pre_reg <= pre_wrap ? 6'h00 : pre_reg + 6'h01;
            if (pre_wrap)
                stp_reg <= (stp_reg == tt_res_reg) ? REG8_RESET : stp_reg + 8'h01;
            if (tt_step)
                tt_reg <= tt_reg + 16'h0001;  // [R8]
        end
    end

    assign time_tag = tt_reg;

    // Interrupt: held until the message ends, then until acknowledged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 3'h0;
            irq_reg  <= 1'b0;
        end else begin
            if (irq_set)
                pend_reg <= 3'h0;
            else
                pend_reg <= pend_reg | int_src;
            if (irq_set)
                irq_reg <= 1'b1;  // [R2]
            else if (wr_int_rst)
                irq_reg <= 1'b0;  // [R23]
        end
    end

    assign irq = irq_reg;

    // Status response window in microseconds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_act_reg   <= 1'b0;
            us_pre_reg     <= 4'h0;
            us_cnt_reg     <= REG8_RESET;
            resp_valid_reg <= 1'b0;
            resp_late_reg  <= 1'b0;
        end else begin
            resp_valid_reg <= resp_act_reg && cmd.resp_seen && in_time;  // [R19]
            resp_late_reg  <= resp_act_reg && expire && !cmd.resp_seen;  // [R19]
            if (cmd.resp_start) begin
                resp_act_reg <= 1'b1;
                us_pre_reg   <= 4'h0;
                us_cnt_reg   <= REG8_RESET;
            end else if (resp_act_reg) begin
                if (cmd.resp_seen || expire)
                    resp_act_reg <= 1'b0;
                us_pre_reg <= us_tick ? 4'h0 : us_pre_reg + 4'h1;
                if (us_tick)
                    us_cnt_reg <= us_cnt_reg + 8'h01;
            end
        end
    end

    assign resp_valid = resp_valid_reg;
    assign resp_late  = resp_late_reg;

    // Command word classification
    wire sa_is_0  = cmd.subaddr == SA_ZERO;
    wire sa_is_31 = cmd.subaddr == SA_31;
    assign is_mode_code = (mode_sa_reg == 2'b01) ? sa_is_0 :
                          (mode_sa_reg == 2'b10) ? sa_is_31 :
                          (sa_is_0 || sa_is_31);  // [R17]
    assign is_broadcast = bcast_reg && cmd.rt_addr == RT_BCAST;  // [R18]

    // Read mux; registers sharing an address follow the operating mode
    wire [15:0] fw_opt = {6'h00, FW_IS_1760, !FW_IS_1760, 8'h00};  // [R20]
    wire [7:0] rd_mux =
        (bus.addr == ADDR_FW_REV)    ? {FW_MAJOR, FW_MINOR} :  // [R21]
        (bus.addr == ADDR_FW_OPT_LO) ? fw_opt[7:0] :
        (bus.addr == ADDR_FW_OPT_HI) ? fw_opt[15:8] :
        (bus.addr == ADDR_RESP_TO)   ? resp_to_reg :
        (bus.addr == ADDR_BCAST)     ? {7'h00, bcast_reg} :
        (bus.addr == ADDR_MODE_SA)   ? {6'h00, mode_sa_reg} :
        (bus.addr == ADDR_NMP_LO)    ? (mode_lut ? last_blk_reg : nmp_reg[7:0]) :
        (bus.addr == ADDR_NMP_HI)    ? (mode_lut ? 8'h00 : nmp_reg[15:8]) :
        (bus.addr == ADDR_TRIG_EBP)  ? (mode_seq ? trig_reg : ebp_reg[7:0]) :
        (bus.addr == ADDR_CNT_EBP)   ? (mode_seq ? msg_cnt_reg : ebp_reg[15:8]) :
        (bus.addr == ADDR_TT_RES)    ? tt_res_reg :
        (bus.addr == ADDR_STATUS)    ? {5'h00, stat_reg} :  // [R4]
        (bus.addr == ADDR_INT_EN)    ? {5'h00, int_en_reg} :
        8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= bus.rd ? rd_mux : 8'h00;
    end

    assign rdata = rdata_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_irq_msg_end: assert property ($rose(irq) |-> $past(msg.done) && $past(run))  // [R2]
        else $error("interrupt raised outside message end");
    chk_irq_enable_gate: assert property (
        $rose(irq) |-> $past(|(int_en_reg & {match_evt, ev_rip, ev_tw})) || $past(|pend_reg))  // [R1]
        else $error("interrupt raised without an enabled condition");
    chk_irq_ack_clear: assert property (wr_int_rst && !irq_set |=> !irq)  // [R23]
        else $error("interrupt reset write did not drop interrupt");
    chk_status_reserved_zero: assert property (
        bus.rd && bus.addr == ADDR_STATUS |=> rdata[7:3] == 5'h00)  // [R4]
        else $error("status reserved bits not zero");
    chk_flag_sw_clear: assert property (
        $fell(stat_reg[STAT_RIP_BIT]) |-> $past(wr_status && bus.wdata[STAT_RIP_BIT]))  // [R7]
        else $error("reception flag cleared without software");
    chk_busy_hold_time: assert property (
        msg.done && !mode_seq && !msg.start ##1 (!ev_busy && !wr_status && !msg.done) [*8]
        |-> stat_reg[STAT_TWB_BIT] == $past(stat_reg[STAT_TWB_BIT], 8))  // [R6]
        else $error("busy cleared too soon after message end");
    chk_busy_seq_mode: assert property (mode_seq && msg.start && !msg.trig_word && !stat_reg[0]
        && !wr_status |=> !stat_reg[STAT_TWB_BIT])  // [R5]
        else $error("busy set in sequential mode");
    chk_counter_range: assert property (msg_cnt_reg <= MSG_CNT_MAX)  // [R10]
        else $error("message counter above range");
    chk_first_no_inc: assert property (
        msg.start && !first_seen_reg |=> $stable(msg_cnt_reg))  // [R11]
        else $error("counter moved on first message");
    chk_match_flag: assert property (match_evt |=> stat_reg[STAT_CTM_BIT])  // [R12]
        else $error("counter match flag not set");
    chk_stop_trigger: assert property (
        match_evt && stop_on_trigger && run |=> !store_en)  // [R13]
        else $error("storage continued after stop on trigger");
    chk_tt_step: assert property ($changed(tt_reg) |-> $past(pre_reg) == TT_STEP_CYC - 6'h01)  // [R8]
        else $error("time tag stepped off the 4 us grid");
    chk_nmp_range: assert property (nmp_reg <= NMP_MAX)  // [R15]
        else $error("next message pointer out of range");
    chk_ebp_range: assert property (
        ebp_reg == PTR_RESET || (ebp_reg >= LL_AREA_END[15:0] && ebp_reg <= LL_SPILL_END[15:0]))  // [R14]
        else $error("end buffer pointer out of range");
    chk_last_block: assert property (
        mode_lut && run && msg.done |=> last_blk_reg == $past(msg.lut_block))  // [R16]
        else $error("last block not loaded at message end");
    chk_resp_exclusive: assert property (!(resp_valid && resp_late))  // [R19]
        else $error("response both valid and late");
    chk_busy_with_rip: assert property (  // [R6]
        !mode_seq && store_en && msg.start |=> stat_reg[STAT_TWB_BIT] && stat_reg[STAT_RIP_BIT])
        else $error("busy not set with reception");
    chk_mode_sa_zero: assert property (  // [R17]
        mode_sa_reg == 2'b01 |-> is_mode_code == (cmd.subaddr == SA_ZERO))
        else $error("mode code select 01 not limited to subaddress 0");
    chk_bcast_only_31: assert property (is_broadcast |-> bcast_reg && cmd.rt_addr == RT_BCAST)  // [R18]
        else $error("broadcast flagged for another address");
    chk_match_sw_clear: assert property (  // [R7]
        $fell(stat_reg[STAT_CTM_BIT]) |-> $past(wr_status && bus.wdata[STAT_CTM_BIT]))
        else $error("match flag cleared without software");
    chk_counter_step: assert property (  // [R10]
        $changed(msg_cnt_reg) |-> msg_cnt_reg == $past(msg_cnt_reg) + 8'h01 || msg_cnt_reg == REG8_RESET)
        else $error("message counter skipped a value");

endmodule
`default_nettype wire

// *** bmcs_traffic_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bmcs_traffic_model
    import bmcs_pkg::*;
(
    // Clock
    input  wire logic         clk,
    // Far-side bus events
    output var bmcs_msg_type  msg,
    output var bmcs_cmd_type  cmd
);
    initial begin
        msg = '0;
        cmd = '0;
    end
    task automatic msg_start();
        @(posedge clk) msg.start <= 1'b1;
        @(posedge clk) msg.start <= 1'b0;
    endtask
    task automatic trig();
        @(posedge clk) msg.trig_word <= 1'b1;
        @(posedge clk) msg.trig_word <= 1'b0;
    endtask
    // Length and block are only good with done; garble them afterwards
    task automatic msg_done(input logic [5:0] len, input logic [7:0] blk);
        @(posedge clk) begin
            msg.done <= 1'b1;
            msg.len <= len;
            msg.lut_block <= blk;
        end
        @(posedge clk) begin
            msg.done <= 1'b0;
            msg.len <= ~len;
            msg.lut_block <= ~blk;
        end
    endtask
    task automatic set_cmd(input logic [4:0] rt, input logic [4:0] sa);
        @(posedge clk) begin
            cmd.rt_addr <= rt;
            cmd.subaddr <= sa;
        end
    endtask
    // Zero delay means the terminal never answers
    task automatic resp(input int dly);
        @(posedge clk) cmd.resp_start <= 1'b1;
        @(posedge clk) cmd.resp_start <= 1'b0;
        if (dly > 0) begin
            repeat (dly - 1) @(posedge clk);
            @(posedge clk) cmd.resp_seen <= 1'b1;
            @(posedge clk) cmd.resp_seen <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb_bus_monitor_control_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_bus_monitor_control_status_regs
    import bmcs_pkg::*;
();
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    bmcs_bus_type  bus = '0;
    bmcs_mode_type op_mode = BMCS_SEQ;
    logic          run = 1'b0;
    logic          stop_on_trigger = 1'b0;
    logic [7:0]    rdata;
    logic          store_en, is_mode_code, is_broadcast, resp_valid, resp_late, irq;
    logic [15:0]   time_tag, ent, t0;
    bmcs_msg_type  msg;
    bmcs_cmd_type  cmd;
    logic          rd_seen = 1'b0;
    logic [15:0]   exp_q[$];
    logic [7:0]    v;
    logic [4:0]    sa;
    logic          e;
    int            err_total = 0;
    int            checked = 0;
    int            n;
    logic [15:0]   rw_a[6] = '{ADDR_TT_RES, ADDR_RESP_TO, ADDR_BCAST, ADDR_MODE_SA, ADDR_INT_EN, ADDR_TRIG_EBP};
    logic [7:0]    rw_m[6] = '{8'hFF, 8'hFF, 8'h01, 8'h03, 8'h07, 8'hFF};

    always #50 clk = ~clk;

    bmcs_regs i_bmcs_regs (
        .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .op_mode(op_mode), .run(run),
        .stop_on_trigger(stop_on_trigger), .store_en(store_en), .msg(msg), .cmd(cmd),
        .is_mode_code(is_mode_code), .is_broadcast(is_broadcast), .resp_valid(resp_valid),
        .resp_late(resp_late), .time_tag(time_tag), .irq(irq)
    );
    bmcs_traffic_model i_bmcs_traffic_model (.clk(clk), .msg(msg), .cmd(cmd));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) begin
            bus.addr <= a;
            bus.wdata <= d;
            bus.wr <= 1'b1;
        end
        @(posedge clk) bus.wr <= 1'b0;
    endtask
    // Expected value goes to the queue; the monitor below settles it
    task automatic rd(input logic [15:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
        @(posedge clk) begin
            bus.addr <= a;
            bus.rd <= 1'b1;
        end
        exp_q.push_back({m, x});
        @(posedge clk) bus.rd <= 1'b0;
    endtask
    task automatic one_msg(input logic [5:0] len);
        i_bmcs_traffic_model.msg_start();
        i_bmcs_traffic_model.msg_done(len, 8'h00);
    endtask
    task automatic set_run(input logic r);
        @(posedge clk) run <= r;
    endtask

    always @(posedge clk) rd_seen <= bus.rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            ent = exp_q.pop_front();
            chk("rdata", {8'h00, ent[7:0] & ent[15:8]}, {8'h00, rdata & ent[15:8]});
        end
    end

    initial begin
        #(100 * 20000);
        err_total++;
        end_sim();
    end

    initial begin
        void'($urandom(87515));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("irq", 16'h0000, irq);
        rd(ADDR_RESP_TO, RESP_TO_RESET);
        rd(ADDR_FW_REV, 8'h10);
        rd(ADDR_FW_OPT_LO, 8'h00);
        rd(ADDR_FW_OPT_HI, 8'h01);
        rd(ADDR_STATUS, 8'h00);
        rd(16'h3E90, 8'h00);
        wr(ADDR_FW_REV, 8'hFF);
        rd(ADDR_FW_REV, 8'h10);
        foreach (rw_a[i]) begin
            v = 8'($urandom);
            wr(rw_a[i], v);
            rd(rw_a[i], v & rw_m[i]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_MODE_SA, 8'(c));
            for (int s = 0; s < 3; s++) begin
                sa = (s == 0) ? SA_ZERO : (s == 1) ? SA_31 : 5'h05;
                i_bmcs_traffic_model.set_cmd(5'h03, sa);
                @(negedge clk);
                e = (s == 0 && c != 2) || (s == 1 && c != 1);
                chk("is_mode_code", e, is_mode_code);
            end
        end
        for (int b = 0; b < 2; b++) begin
            wr(ADDR_BCAST, 8'(b));
            for (int t = 0; t < 2; t++) begin
                i_bmcs_traffic_model.set_cmd(t ? RT_BCAST : 5'h1E, 5'h05);
                @(negedge clk);
                chk("is_broadcast", b && t, is_broadcast);
            end
        end
        // Halted while programming
        wr(ADDR_TT_RES, 8'h01);
        wr(ADDR_TRIG_EBP, 8'h02);
        wr(ADDR_INT_EN, 8'h04);
        wr(ADDR_STATUS, 8'h07);
        set_run(1'b1);
        for (int k = 0; k < 2; k++) begin
            t0 = time_tag;
            n = 0;
            while (time_tag === t0 && n < 300) begin
                @(negedge clk);
                n++;
            end
        end
        chk("time tag step", 16'h0050, 16'(n));
        one_msg(6'h05);
        rd(ADDR_CNT_EBP, 8'h00);
        i_bmcs_traffic_model.msg_start();
        rd(ADDR_CNT_EBP, 8'h01);
        i_bmcs_traffic_model.msg_done(6'h05, 8'h00);
        i_bmcs_traffic_model.msg_start();
        rd(ADDR_CNT_EBP, 8'h02);
        rd(ADDR_STATUS, 8'h06);
        @(negedge clk);
        chk("irq mid message", 16'h0000, irq);
        i_bmcs_traffic_model.msg_done(6'h05, 8'h00);
        @(negedge clk);
        chk("irq at end", 16'h0001, irq);
        chk("store_en continue", 16'h0001, store_en);
        wr(ADDR_INT_RESET, 8'($urandom));
        @(negedge clk);
        chk("irq after reset write", 16'h0000, irq);
        rd(ADDR_STATUS, 8'h06);
        wr(ADDR_STATUS, 8'h07);
        rd(ADDR_STATUS, 8'h00);
        i_bmcs_traffic_model.msg_start();
        i_bmcs_traffic_model.trig();
        rd(ADDR_CNT_EBP, 8'h03);
        rd(ADDR_STATUS, 8'h03);
        i_bmcs_traffic_model.msg_done(6'h05, 8'h00);
        set_run(1'b0);
        @(posedge clk) stop_on_trigger <= 1'b1;
        wr(ADDR_TRIG_EBP, 8'h05);
        set_run(1'b1);
        repeat (3) one_msg(6'h05);
        @(negedge clk);
        chk("store_en stopped", 16'h0000, store_en);
        chk("irq at stop", 16'h0001, irq);
        one_msg(6'h05);
        rd(ADDR_CNT_EBP, 8'h05);
        set_run(1'b0);
        @(posedge clk) begin
            stop_on_trigger <= 1'b0;
            op_mode <= BMCS_LL;
        end
        wr(ADDR_STATUS, 8'h07);
        set_run(1'b1);
        i_bmcs_traffic_model.msg_start();
        rd(ADDR_STATUS, 8'h03);
        i_bmcs_traffic_model.msg_done(6'h3F, 8'h00);
        repeat (35) @(posedge clk);
        rd(ADDR_STATUS, 8'h03);
        repeat (20) @(posedge clk);
        rd(ADDR_STATUS, 8'h02);
        rd(ADDR_NMP_LO, 8'h7E);
        rd(ADDR_TRIG_EBP, 8'h00);
        repeat (104) one_msg(6'h3F);
        rd(ADDR_NMP_LO, 8'hAE);
        rd(ADDR_NMP_HI, 8'h33);
        rd(ADDR_CNT_EBP, 8'h00);
        one_msg(6'h3F);
        rd(ADDR_TRIG_EBP, 8'h2C);
        rd(ADDR_CNT_EBP, 8'h34);
        rd(ADDR_NMP_LO, 8'h00);
        set_run(1'b0);
        @(posedge clk) op_mode <= BMCS_LUT;
        set_run(1'b1);
        v = 8'($urandom);
        i_bmcs_traffic_model.msg_start();
        i_bmcs_traffic_model.msg_done(6'h04, v);
        rd(ADDR_NMP_LO, v);
        rd(ADDR_NMP_HI, 8'h00);
        wr(ADDR_RESP_TO, 8'h03);
        i_bmcs_traffic_model.resp(10);
        @(negedge clk);
        chk("resp_valid", 16'h0001, resp_valid);
        i_bmcs_traffic_model.resp(0);
        n = 0;
        while (resp_late !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("late window", 16'h0001, n >= 26 && n <= 32);
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
